//--- pbcr_regs.sv
`include "pbcr_defines.svh"
module pbcr_regs
   import pbcr_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR_DEF = 5'h01,
   parameter int         DEAD_CYC     = 90000000
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n,
   input  wire logic        power_down_pin,
   input  wire logic [4:0]  strap_phy_addr,
   input  wire logic        neg_speed,
   input  wire logic        neg_duplex,
   input  wire logic        neg_busy,
   output logic             neg_restart,
   output logic             mii_isolate,
   output logic             mii_enable,
   output logic             loopback_en,
   output logic             rx_blank,
   output logic             speed_100,
   output logic             full_duplex,
   output logic             col_test
);

   logic [2:0]  mdc_s_r;
   logic [1:0]  mdi_s_r;
   logic [1:0]  pd_s_r;
   logic        mdc_rise;
   logic        mdc_fall;
   logic        pd_pin_q;
   pbcr_state_t st_r;
   logic [5:0]  cnt_r;
   logic [13:0] hdr_r;
   logic [15:0] sh_r;
   logic        rd_r;
   logic        hit_r;
   logic [4:0]  phy_addr_r;
   logic [1:0]  strap_cnt_r;
   logic [4:0]  strap_m_r;
   logic [4:0]  strap_q_r;
   logic [15:0] ctrl_r;
   logic [7:0]  srst_cnt_r;
   logic        restart_req_r;
   logic        loop_q_r;
   logic [31:0] dead_r;
   logic [15:0] rdata;
   logic [15:0] ctrl_view;
   logic        wr_pulse;
   logic [15:0] wdata;
   logic        pd_any;

   // Bring management clock, data and pin into the system clock.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mdc_s_r <= 3'h0;
         mdi_s_r <= 2'h0;
         pd_s_r  <= 2'h0;
      end else begin
         mdc_s_r <= {mdc_s_r[1:0], mdc};
         mdi_s_r <= {mdi_s_r[0], mdio_i};
         pd_s_r  <= {pd_s_r[0], power_down_pin};
      end
   end
   assign mdc_rise = mdc_s_r[1] & ~mdc_s_r[2];
   assign mdc_fall = ~mdc_s_r[1] & mdc_s_r[2];
   assign pd_pin_q = pd_s_r[1];

   // Pass the address straps through two flops, then catch them once.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_m_r   <= 5'h00;
         strap_q_r   <= 5'h00;
         strap_cnt_r <= 2'h0;
         phy_addr_r  <= PHY_ADDR_DEF;
      end else begin
         strap_m_r <= strap_phy_addr;
         strap_q_r <= strap_m_r;
         if (strap_cnt_r != 2'h3)
            strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == 2'h2)
            phy_addr_r <= strap_q_r;
      end
   end

   // Control register view: negotiated results replace manual bits.
   always_comb begin
      ctrl_view = ctrl_r & `PBCR_CTRL_WMASK;
      if (ctrl_r[`PBCR_B_ANEN]) begin
         ctrl_view[`PBCR_B_SPEED]  = neg_speed;
         ctrl_view[`PBCR_B_DUPLEX] = neg_duplex;
      end
   end

   // Read mux; unmapped and reserved registers return zero.
   always_comb begin
      case (hdr_r[4:0])
         `PBCR_A_CTRL:   rdata = ctrl_view;
         `PBCR_A_RLATCH: rdata = {11'h000, phy_addr_r};
         default:        rdata = 16'h0000;
      endcase
   end

   // Frame receiver, sampled on management clock rising edges.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r  <= PBCR_IDLE;
         cnt_r <= 6'h0;
         hdr_r <= 14'h0;
         sh_r  <= 16'h0;
         rd_r  <= 1'b0;
         hit_r <= 1'b0;
      end else if (mdc_rise) begin
         case (st_r)
            PBCR_IDLE: begin
               if (mdi_s_r[1]) begin
                  if (cnt_r != `PBCR_PRE_BITS)
                     cnt_r <= cnt_r + 6'd1;
               end else if (cnt_r == `PBCR_PRE_BITS) begin
                  st_r <= PBCR_ST;
               end else begin
                  cnt_r <= 6'h0;
               end
            end
            PBCR_ST: begin
               if (mdi_s_r[1]) begin
                  st_r  <= PBCR_HDR;
                  cnt_r <= 6'h0;
               end else begin
                  st_r  <= PBCR_IDLE;
                  cnt_r <= 6'h0;
               end
            end
            PBCR_HDR: begin
               hdr_r <= {hdr_r[12:0], mdi_s_r[1]};
               cnt_r <= cnt_r + 6'd1;
               if (cnt_r == 6'd11) begin
                  st_r  <= PBCR_TA;
                  cnt_r <= 6'h0;
                  rd_r  <= (hdr_r[10:9] == `PBCR_OP_READ);
                  hit_r <= (hdr_r[8:4] == phy_addr_r);
               end
            end
            PBCR_TA: begin
               cnt_r <= cnt_r + 6'd1;
               if (cnt_r == 6'd1) begin
                  st_r  <= PBCR_DATA;
                  cnt_r <= 6'h0;
                  sh_r  <= rdata;
               end
            end
            PBCR_DATA: begin
               sh_r  <= {sh_r[14:0], mdi_s_r[1]};
               cnt_r <= cnt_r + 6'd1;
               if (cnt_r == 6'd15) begin
                  st_r  <= PBCR_IDLE;
                  cnt_r <= 6'h0;
               end
            end
            default: begin
               st_r  <= PBCR_IDLE;
               cnt_r <= 6'h0;
            end
         endcase
      end
   end

   // A write completes on the sixteenth data bit, which is not yet in the
   // shifter, so the word is built from the shifter and that last bit.
   assign wdata    = {sh_r[14:0], mdi_s_r[1]};
   assign wr_pulse = mdc_rise && st_r == PBCR_DATA && cnt_r == 6'd15 &&
                     !rd_r && hit_r && hdr_r[11:10] == `PBCR_OP_WRITE;

   // Read data driven after the falling edge; the enable is low to drive.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mdio_o    <= 1'b1;
         mdio_oe_n <= 1'b1;
      end else if (mdc_fall) begin
         mdio_oe_n <= !(rd_r && hit_r &&
                        ((st_r == PBCR_TA && cnt_r == 6'd1) ||
                         st_r == PBCR_DATA));
         mdio_o    <= (st_r == PBCR_DATA) ? sh_r[15] : 1'b0;
      end
   end

   // Control register with software reset and self-clearing restart.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r        <= `PBCR_CTRL_RST;
         srst_cnt_r    <= 8'h0;
         restart_req_r <= 1'b0;
      end else if (ctrl_r[`PBCR_B_RESET]) begin
         srst_cnt_r <= srst_cnt_r + 8'd1;
         if (srst_cnt_r == `PBCR_SRST_CYC) begin
            ctrl_r        <= `PBCR_CTRL_RST;
            srst_cnt_r    <= 8'h0;
            restart_req_r <= 1'b0;
         end
      end else begin
         if (wr_pulse && hdr_r[4:0] == `PBCR_A_CTRL) begin
            ctrl_r <= wdata & `PBCR_CTRL_WMASK;
            if (!wdata[`PBCR_B_RESTART] || !wdata[`PBCR_B_ANEN])
               ctrl_r[`PBCR_B_RESTART] <= 1'b0;
            restart_req_r <= wdata[`PBCR_B_RESTART] & wdata[`PBCR_B_ANEN];
         end else if (restart_req_r && neg_busy) begin
            ctrl_r[`PBCR_B_RESTART] <= 1'b0;
            restart_req_r           <= 1'b0;
         end
      end
   end

   // Loopback dead time after enabling at 100M.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         loop_q_r <= 1'b0;
         dead_r   <= 32'h0;
      end else begin
         loop_q_r <= ctrl_r[`PBCR_B_LOOP];
         if (ctrl_r[`PBCR_B_LOOP] && !loop_q_r && ctrl_view[`PBCR_B_SPEED])
            dead_r <= 32'(DEAD_CYC);
         else if (dead_r != 32'h0)
            dead_r <= dead_r - 32'h1;
      end
   end

   assign pd_any = ctrl_r[`PBCR_B_PDOWN] | pd_pin_q;

   // Registered controls toward the data path.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         neg_restart <= 1'b0;
         mii_isolate <= 1'b0;
         mii_enable  <= 1'b0;
         loopback_en <= 1'b0;
         rx_blank    <= 1'b0;
         speed_100   <= 1'b1;
         full_duplex <= 1'b1;
         col_test    <= 1'b0;
      end else begin
         neg_restart <= restart_req_r & ~neg_busy;
         mii_isolate <= ctrl_r[`PBCR_B_ISO];
         mii_enable  <= ~pd_any & ~ctrl_r[`PBCR_B_ISO] &
                        ~ctrl_r[`PBCR_B_RESET];
         loopback_en <= ctrl_r[`PBCR_B_LOOP] & ~pd_any;
         rx_blank    <= dead_r != 32'h0;
         speed_100   <= ctrl_view[`PBCR_B_SPEED];
         full_duplex <= ctrl_view[`PBCR_B_DUPLEX];
         col_test    <= ctrl_r[`PBCR_B_COLTEST];
      end
   end

   // Software reset must finish within its fixed time.
   property p_srst_done;
      @(posedge sys_clk) disable iff (rst)
      $rose(ctrl_r[`PBCR_B_RESET]) |-> ##[1:20] !ctrl_r[`PBCR_B_RESET];
   endproperty
   a_srst_done: assert property (p_srst_done)
      else $error("software reset did not self clear");

   // Powered down or isolated means the data path is off.
   property p_pd_off;
      @(posedge sys_clk) disable iff (rst)
      pd_any |=> !mii_enable;
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("data path enabled during power down");

   property p_iso;
      @(posedge sys_clk) disable iff (rst)
      ctrl_r[`PBCR_B_ISO] |=> mii_isolate && !mii_enable;
   endproperty
   a_iso: assert property (p_iso)
      else $error("isolate not applied");

   // Negotiated speed shown while negotiation is enabled.
   property p_neg_view;
      @(posedge sys_clk) disable iff (rst)
      ctrl_r[`PBCR_B_ANEN] |=> speed_100 == $past(neg_speed) &&
                               full_duplex == $past(neg_duplex);
   endproperty
   a_neg_view: assert property (p_neg_view)
      else $error("control view ignores negotiation");

   // Restart never requested with negotiation off.
   property p_restart_en;
      @(posedge sys_clk) disable iff (rst)
      neg_restart |-> $past(ctrl_r[`PBCR_B_ANEN]);
   endproperty
   a_restart_en: assert property (p_restart_en)
      else $error("restart issued with negotiation off");

   // Reserved control bits always read zero.
   property p_rsvd;
      @(posedge sys_clk) disable iff (rst)
      ctrl_r[6:0] == 7'h00;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits nonzero");

   // Read data still drives the pin while powered down.
   property p_mdio_pd;
      @(posedge sys_clk) disable iff (rst)
      (mdc_fall && pd_any && rd_r && hit_r && st_r == PBCR_DATA)
         |=> !mdio_oe_n;
   endproperty
   a_mdio_pd: assert property (p_mdio_pd)
      else $error("read data not driven");

   // Loopback at 100M enabling blanks receive.
   property p_dead;
      @(posedge sys_clk) disable iff (rst)
      (ctrl_r[`PBCR_B_LOOP] && !loop_q_r && ctrl_view[`PBCR_B_SPEED])
         |=> ##1 rx_blank;
   endproperty
   a_dead: assert property (p_dead)
      else $error("loopback dead time missing");

endmodule

//--- pbcr_defines.svh
`ifndef PBCR_DEFINES_SVH
`define PBCR_DEFINES_SVH
// Register indices on the management bus.
`define PBCR_A_CTRL      5'h00
`define PBCR_A_EXP       5'h06
`define PBCR_A_VCFG      5'h10
`define PBCR_A_VCST      5'h11
`define PBCR_A_TBCS      5'h12
`define PBCR_A_PDOR      5'h13
`define PBCR_A_VCF2      5'h14
`define PBCR_A_IMS       5'h15
`define PBCR_A_RXERR     5'h16
`define PBCR_A_DISC      5'h17
`define PBCR_A_RLATCH    5'h18
`define PBCR_A_RADV      5'h19
`define PBCR_A_RLPA      5'h1a
`define PBCR_A_PSAVE     5'h1d
`define PBCR_A_MON       5'h1e
// Control register field positions.
`define PBCR_B_RESET     15
`define PBCR_B_LOOP      14
`define PBCR_B_SPEED     13
`define PBCR_B_ANEN      12
`define PBCR_B_PDOWN     11
`define PBCR_B_ISO       10
`define PBCR_B_RESTART   9
`define PBCR_B_DUPLEX    8
`define PBCR_B_COLTEST   7
// Control register reset value, bits 15..7 writable, 6..0 reserved.
`define PBCR_CTRL_RST    16'h3100
`define PBCR_CTRL_WMASK  16'hff80
// Frame preamble length and opcodes.
`define PBCR_PRE_BITS    6'd32
`define PBCR_OP_READ     2'b10
`define PBCR_OP_WRITE    2'b01
// Timing.
`define PBCR_SRST_CYC    8'd16
`define PBCR_DEAD_MS     720
`endif

//--- pbcr_pkg.sv
package pbcr_pkg;
   // Serial management frame receiver states, Gray coded along the path.
   typedef enum logic [2:0] {
      PBCR_IDLE = 3'b000,
      PBCR_ST   = 3'b001,
      PBCR_HDR  = 3'b011,
      PBCR_TA   = 3'b010,
      PBCR_DATA = 3'b110
   } pbcr_state_t;
endpackage

//--- pbcr_mac_model.sv
// Station management master: makes the management clock and frames.
module pbcr_mac_model (
   input  wire logic sys_clk,
   input  wire logic mdio_o,
   input  wire logic mdio_oe_n,
   output logic      mdc,
   output logic      mdio_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic m_oe;
   logic m_val;

   // Shared line with pull-up: device wins when enabled, else master, else 1.
   assign mdio_line = !mdio_oe_n ? mdio_o : (m_oe ? m_val : 1'b1);

   // The clock stands low between frames and the line is released.
   initial begin
      mdc = 1'b0;
      m_oe = 1'b0;
      m_val = 1'b1;
   end

   // One bit: drive low half, sample just before the rising edge.
   task automatic bit_cyc(input logic oe, input logic v, output logic seen);
      m_oe = oe;
      m_val = v;
      repeat (8) @(negedge sys_clk);
      seen = mdio_line;
      mdc = 1'b1;
      repeat (8) @(negedge sys_clk);
      mdc = 1'b0;
   endtask

   // Whole frame; a read releases the line from the turnaround on.
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] rg, input logic [15:0] wd,
                        input int pre, output logic [15:0] rd,
                        output logic [1:0] ta);
      logic [13:0] hdr;
      logic        s;
      logic        wr;
      hdr = {2'b01, op, pa, rg};
      wr = (op == 2'b01);
      @(negedge sys_clk);
      for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      bit_cyc(wr, 1'b1, ta[1]);
      bit_cyc(wr, 1'b0, ta[0]);
      for (int i = 15; i >= 0; i--) bit_cyc(wr, wd[i], rd[i]);
      m_oe = 1'b0;
   endtask
endmodule

//--- phy_basic_control_registers_bench.sv
`include "pbcr_defines.svh"
module phy_basic_control_registers_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] PA = 5'h05;
   logic       sys_clk, rst, mdc, mdio_line, mdio_o, mdio_oe_n;
   logic       power_down_pin, neg_speed, neg_duplex, neg_busy;
   logic       neg_restart, mii_isolate, mii_enable, loopback_en;
   logic       rx_blank, speed_100, full_duplex;
   logic [4:0] strap_phy_addr;
   int         n_mismatch = 0;
   int         n_tests = 0;

   // Device under test with a short loopback dead time; its default
   // address differs from the strap, so only a caught strap answers.
   pbcr_regs #(.PHY_ADDR_DEF(5'h1e), .DEAD_CYC(40)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_i(mdio_line),
      .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
      .power_down_pin(power_down_pin), .strap_phy_addr(strap_phy_addr),
      .neg_speed(neg_speed), .neg_duplex(neg_duplex),
      .neg_busy(neg_busy), .neg_restart(neg_restart),
      .mii_isolate(mii_isolate), .mii_enable(mii_enable),
      .loopback_en(loopback_en), .rx_blank(rx_blank),
      .speed_100(speed_100), .full_duplex(full_duplex), .col_test());

   // Management master on the far side.
   pbcr_mac_model i_mac (
      .sys_clk(sys_clk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
      .mdc(mdc), .mdio_line(mdio_line));

   // Free running 125 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] pa, input int pre,
                     input logic [4:0] rg, input logic [15:0] v);
      logic [15:0] d;
      logic [1:0]  t;
      i_mac.frame(`PBCR_OP_WRITE, pa, rg, v, pre, d, t);
   endtask

   task automatic rd(input logic [4:0] rg, input logic [15:0] exp);
      logic [15:0] d;
      logic [1:0]  t;
      i_mac.frame(`PBCR_OP_READ, PA, rg, 16'h0000, 32, d, t);
      check("turnaround", {14'h0000, t}, 16'h0002);
      check("read data", d, exp);
   endtask

   // A hang is cut short and counted.
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_mismatch++;
      conclude();
   end

   // Main sequence; inputs change on the falling edge.
   initial begin
      rst = 1'b1;
      power_down_pin = 1'b0;
      strap_phy_addr = PA;
      neg_speed = 1'b1;
      neg_duplex = 1'b1;
      neg_busy = 1'b0;
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("idle enable", mdio_oe_n, 1'b1);
      rd(`PBCR_A_CTRL, 16'h3100);
      neg_speed = 1'b0;
      neg_duplex = 1'b0;
      rd(`PBCR_A_CTRL, 16'h1000);
      check("speed", speed_100, 1'b0);
      neg_speed = 1'b1;
      neg_duplex = 1'b1;
      rd(`PBCR_A_RLATCH, 16'h0005);
      rd(5'h02, 16'h0000);
      rd(`PBCR_A_RADV, 16'h0000);
      wr(PA, 32, `PBCR_A_CTRL, 16'h017f);
      rd(`PBCR_A_CTRL, 16'h0100);
      check("manual speed", speed_100, 1'b0);
      check("duplex", full_duplex, 1'b1);
      wr(5'h06, 32, `PBCR_A_CTRL, 16'h0800);
      wr(PA, 31, `PBCR_A_CTRL, 16'h0800);
      rd(`PBCR_A_CTRL, 16'h0100);
      wr(PA, 32, `PBCR_A_CTRL, 16'h6000);
      check("loopback", loopback_en, 1'b1);
      check("dead time", rx_blank, 1'b1);
      repeat (50) @(negedge sys_clk);
      check("dead time end", rx_blank, 1'b0);
      wr(PA, 32, `PBCR_A_CTRL, 16'h0400);
      check("isolate", mii_isolate, 1'b1);
      check("isolated enable", mii_enable, 1'b0);
      rd(`PBCR_A_CTRL, 16'h0400);
      wr(PA, 32, `PBCR_A_CTRL, 16'h0800);
      check("power down", mii_enable, 1'b0);
      rd(`PBCR_A_CTRL, 16'h0800);
      wr(PA, 32, `PBCR_A_CTRL, 16'h0000);
      power_down_pin = 1'b1;
      rd(`PBCR_A_CTRL, 16'h0000);
      check("pin power down", mii_enable, 1'b0);
      power_down_pin = 1'b0;
      wr(PA, 32, `PBCR_A_CTRL, 16'h0200);
      rd(`PBCR_A_CTRL, 16'h0000);
      check("restart off", neg_restart, 1'b0);
      wr(PA, 32, `PBCR_A_CTRL, 16'h1200);
      check("restart", neg_restart, 1'b1);
      rd(`PBCR_A_CTRL, 16'h3300);
      neg_busy = 1'b1;
      for (int k = 0; k < 32 && neg_restart !== 1'b0; k++)
         @(negedge sys_clk);
      check("restart taken", neg_restart, 1'b0);
      if (neg_restart !== 1'b0)
         conclude();
      rd(`PBCR_A_CTRL, 16'h3100);
      wr(PA, 32, `PBCR_A_CTRL, 16'h1000);
      check("restart cleared", neg_restart, 1'b0);
      neg_busy = 1'b0;
      wr(PA, 32, `PBCR_A_CTRL, 16'h4000);
      check("no dead time at 10M", rx_blank, 1'b0);
      wr(PA, 32, `PBCR_A_CTRL, 16'h8000);
      check("soft reset", mii_enable, 1'b0);
      repeat (20) @(negedge sys_clk);
      check("after reset", mii_enable, 1'b1);
      rd(`PBCR_A_CTRL, 16'h3100);
      check("loop cleared", loopback_en, 1'b0);
      conclude();
   end
endmodule
